/* File: hdl/pwt_top.sv */
/*
 two pwm channels with a shared timer selection register and an 8-bit
 register port (read data one cycle after the read strobe).
 assumes the three 8-bit timers live outside and present a 10-bit time base
 and a one-cycle reload pulse each, synchronous to mclk.
*/
//
// Overview of operation
// [R1] channel b timer picked by bits 3:2
// [R2] channel a timer picked by bits 1:0
// [R3] both selection fields reset to 01
// [R4] unimplemented bits ignore writes, read zero
// [R5] selection fields read/write, take effect directly
// [R6] period rollover sets output, latches duty; a zero duty leaves the output low
// [R7] 10-bit duty double-buffered until period match
// [R8] disabled output rests at polarity level
// [R9] selected timer feeds channel duty comparison
`timescale 1ns/10ps
module pwt_top
   import pwt_pkg::*;
(
   input  wire logic       mclk,      // 200 MHz system clock
   input  wire logic       rst,       // synchronous reset, active high
   input  wire logic [2:0] addr,      // register word address
   input  wire logic [7:0] wdata,     // write data
   input  wire logic       wr,        // write strobe
   input  wire logic       rd,        // read strobe
   output logic      [7:0] rdata_q,   // read data, valid cycle after rd
   input  wire logic [9:0] t1_base,   // timer one count and low bits
   input  wire logic [9:0] t2_base,   // timer two count and low bits
   input  wire logic [9:0] t3_base,   // timer three count and low bits
   input  wire logic       t1_reload, // timer one rollover pulse
   input  wire logic       t2_reload, // timer two rollover pulse
   input  wire logic       t3_reload, // timer three rollover pulse
   output logic            pwm_a_q,   // channel a pin
   output logic            pwm_b_q    // channel b pin
);

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [1:0] pick_a_q, pick_a_d;   // chan_a_timer_pick
   logic [1:0] pick_b_q, pick_b_d;   // chan_b_timer_pick
   logic       en_a_q,   en_a_d;     // channel a enable
   logic       pol_a_q,  pol_a_d;    // channel a polarity
   logic       en_b_q,   en_b_d;     // channel b enable
   logic       pol_b_q,  pol_b_d;    // channel b polarity
   logic [9:0] duty_a_q, duty_a_d;   // channel a duty buffer
   logic [9:0] duty_b_q, duty_b_d;   // channel b duty buffer
   logic [7:0] rdata_d;

   ////////////////////////////////////////////////////////////////////////
   // register writes; only implemented bits are stored
   always_comb
   begin
      pick_a_d = pick_a_q;
      pick_b_d = pick_b_q;
      en_a_d   = en_a_q;
      pol_a_d  = pol_a_q;
      en_b_d   = en_b_q;
      pol_b_d  = pol_b_q;
      duty_a_d = duty_a_q;
      duty_b_d = duty_b_q;
      if (wr)
      begin
         unique case (addr)
            PWT_OFF_TSEL :
            begin
               // upper nibble is dropped on the floor
               pick_b_d = wdata[PWT_TSEL_B_MSB:PWT_TSEL_B_LSB]; // [R1] [R5] [R4]
               pick_a_d = wdata[PWT_TSEL_A_MSB:PWT_TSEL_A_LSB]; // [R2] [R5]
            end
            PWT_OFF_A_CTRL :
            begin
               en_a_d  = wdata[PWT_CTRL_EN_BIT];
               pol_a_d = wdata[PWT_CTRL_POL_BIT];
            end
            PWT_OFF_A_DCH : duty_a_d[9:2] = wdata;       // [R7]
            PWT_OFF_A_DCL : duty_a_d[1:0] = wdata[PWT_DCL_MSB:PWT_DCL_LSB]; // [R7]
            PWT_OFF_B_CTRL :
            begin
               en_b_d  = wdata[PWT_CTRL_EN_BIT];
               pol_b_d = wdata[PWT_CTRL_POL_BIT];
            end
            PWT_OFF_B_DCH : duty_b_d[9:2] = wdata;       // [R7]
            PWT_OFF_B_DCL : duty_b_d[1:0] = wdata[PWT_DCL_MSB:PWT_DCL_LSB]; // [R7]
            default : ;  // unmapped address: write ignored
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; every unimplemented bit reads zero
   always_comb
   begin
      rdata_d = PWT_ZERO8;
      if (rd)
      begin
         unique case (addr)
            PWT_OFF_TSEL :
            begin
               rdata_d[PWT_TSEL_B_MSB:PWT_TSEL_B_LSB] = pick_b_q; // [R4] [R5]
               rdata_d[PWT_TSEL_A_MSB:PWT_TSEL_A_LSB] = pick_a_q; // [R5]
            end
            PWT_OFF_A_CTRL :
            begin
               rdata_d[PWT_CTRL_EN_BIT]  = en_a_q;
               rdata_d[PWT_CTRL_OUT_BIT] = pwm_a_q;  // live pin level
               rdata_d[PWT_CTRL_POL_BIT] = pol_a_q;
            end
            PWT_OFF_A_DCH : rdata_d = duty_a_q[9:2];
            PWT_OFF_A_DCL : rdata_d[PWT_DCL_MSB:PWT_DCL_LSB] = duty_a_q[1:0]; // [R4]
            PWT_OFF_B_CTRL :
            begin
               rdata_d[PWT_CTRL_EN_BIT]  = en_b_q;
               rdata_d[PWT_CTRL_OUT_BIT] = pwm_b_q;
               rdata_d[PWT_CTRL_POL_BIT] = pol_b_q;
            end
            PWT_OFF_B_DCH : rdata_d = duty_b_q[9:2];
            PWT_OFF_B_DCL : rdata_d[PWT_DCL_MSB:PWT_DCL_LSB] = duty_b_q[1:0]; // [R4]
            default : rdata_d = PWT_ZERO8;  // unmapped reads zero
         endcase
      end
   end

   // registers only
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pick_a_q <= PWT_TSEL_RST;  // [R3]
         pick_b_q <= PWT_TSEL_RST;  // [R3]
         en_a_q   <= 1'b0;
         pol_a_q  <= 1'b0;
         en_b_q   <= 1'b0;
         pol_b_q  <= 1'b0;
         duty_a_q <= PWT_DUTY_RST;
         duty_b_q <= PWT_DUTY_RST;
         rdata_q  <= PWT_ZERO8;
      end
      else
      begin
         pick_a_q <= pick_a_d;
         pick_b_q <= pick_b_d;
         en_a_q   <= en_a_d;
         pol_a_q  <= pol_a_d;
         en_b_q   <= en_b_d;
         pol_b_q  <= pol_b_d;
         duty_a_q <= duty_a_d;
         duty_b_q <= duty_b_d;
         rdata_q  <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channels; both see all three timers and pick by their own field
   pwt_chan u_chan_a
   (
      .mclk       (mclk),
      .rst        (rst),
      .enable     (en_a_q),
      .polarity   (pol_a_q),
      .timer_pick (pick_a_q),   // [R2] [R9]
      .duty_buf   (duty_a_q),
      .tb_all     ({t3_base, t2_base, t1_base}),
      .reload_all ({t3_reload, t2_reload, t1_reload}),
      .pin_q      (pwm_a_q)
   );

   pwt_chan u_chan_b
   (
      .mclk       (mclk),
      .rst        (rst),
      .enable     (en_b_q),
      .polarity   (pol_b_q),
      .timer_pick (pick_b_q),   // [R1] [R9]
      .duty_buf   (duty_b_q),
      .tb_all     ({t3_base, t2_base, t1_base}),
      .reload_all ({t3_reload, t2_reload, t1_reload}),
      .pin_q      (pwm_b_q)
   );

endmodule

/* File: hdl/pwt_pkg.sv */
/*
 pwm timer-select package: register offsets, field positions, reset values
 and timer selection codes shared by the top and the channel module.
 assumes an 8-bit register port with a 3-bit word address.
*/
package pwt_pkg;
   // register word addresses
   localparam logic [2:0] PWT_OFF_TSEL   = 3'h0; // pwm_timer_select_reg
   localparam logic [2:0] PWT_OFF_A_CTRL = 3'h1; // pwm_a_control
   localparam logic [2:0] PWT_OFF_A_DCH  = 3'h2; // pwm_a_duty_high
   localparam logic [2:0] PWT_OFF_A_DCL  = 3'h3; // pwm_a_duty_low
   localparam logic [2:0] PWT_OFF_B_CTRL = 3'h4; // pwm_b_control
   localparam logic [2:0] PWT_OFF_B_DCH  = 3'h5; // pwm_b_duty_high
   localparam logic [2:0] PWT_OFF_B_DCL  = 3'h6; // pwm_b_duty_low
   // control register fields
   localparam int PWT_CTRL_EN_BIT  = 7; // channel_enable
   localparam int PWT_CTRL_OUT_BIT = 5; // output_level_readback
   localparam int PWT_CTRL_POL_BIT = 4; // output_polarity
   // duty low register field
   localparam int PWT_DCL_MSB = 7;
   localparam int PWT_DCL_LSB = 6;
   // timer select fields
   localparam int PWT_TSEL_B_MSB = 3; // chan_b_timer_pick
   localparam int PWT_TSEL_B_LSB = 2;
   localparam int PWT_TSEL_A_MSB = 1; // chan_a_timer_pick
   localparam int PWT_TSEL_A_LSB = 0;
   // timer selection codes
   typedef enum logic [1:0]
   {
      PWT_TSEL_RSVD = 2'b00,
      PWT_TSEL_ONE  = 2'b01,
      PWT_TSEL_TWO  = 2'b10,
      PWT_TSEL_THR  = 2'b11
   } pwt_tsel_t;
   // reset values
   localparam logic [1:0] PWT_TSEL_RST = 2'h1;
   localparam logic [9:0] PWT_DUTY_RST = 10'h000;
   localparam logic [7:0] PWT_ZERO8    = 8'h00;
endpackage

/* File: hdl/pwt_chan.sv */
/*
 one standard pwm channel: picks one of three 10-bit time bases, keeps a
 double-buffered duty value and drives a registered output pin.
 assumes each timer gives its 10-bit time base and a one-cycle reload pulse
 in the increment cycle where the count clears after its period match.
*/
`timescale 1ns/10ps
module pwt_chan
   import pwt_pkg::*;
(
   input  wire logic        mclk,       // system clock
   input  wire logic        rst,        // synchronous reset, active high
   input  wire logic        enable,     // channel_enable
   input  wire logic        polarity,   // output_polarity, 1 = active low
   input  wire logic [1:0]  timer_pick, // selection code
   input  wire logic [9:0]  duty_buf,   // software-visible duty value
   input  wire logic [29:0] tb_all,     // three time bases, timer one lowest
   input  wire logic [2:0]  reload_all, // three reload pulses
   output logic             pin_q       // pwm output pin
);

   logic [9:0] duty_act_q;  // active duty, copied at reload
   logic [9:0] duty_act_d;
   logic       raw_q;       // active-high waveform before polarity
   logic       raw_d;
   logic       pin_d;
   logic [9:0] tb_sel;      // chosen time base
   logic       reload_sel;  // chosen reload pulse
   logic       tb_valid;    // a real timer is selected

   ////////////////////////////////////////////////////////////////////////
   // time base routing, follows the selection at once
   always_comb
   begin
      tb_sel     = 10'h000;
      reload_sel = 1'b0;
      tb_valid   = 1'b1;
      unique case (pwt_tsel_t'(timer_pick))
         PWT_TSEL_ONE :
         begin
            tb_sel     = tb_all[9:0];  // [R9]
            reload_sel = reload_all[0];
         end
         PWT_TSEL_TWO :
         begin
            tb_sel     = tb_all[19:10]; // [R9]
            reload_sel = reload_all[1];
         end
         PWT_TSEL_THR :
         begin
            tb_sel     = tb_all[29:20]; // [R9]
            reload_sel = reload_all[2];
         end
         PWT_TSEL_RSVD :
         begin
            // reserved code: no time base, waveform freezes
            tb_valid = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // waveform next state
   always_comb
   begin
      duty_act_d = duty_act_q;
      raw_d      = raw_q;
      if (tb_valid && reload_sel)
      begin
         // period rollover: take the buffered duty, start a pulse unless it is zero
         duty_act_d = duty_buf;            // [R6] [R7]
         raw_d      = (duty_buf != 10'h000); // [R6]
      end
      else if (tb_valid && (tb_sel == duty_act_q))
      begin
         // duty beyond the period never matches, so the pin holds
         raw_d = 1'b0;
      end
      // disabled channel rests at the polarity level
      pin_d = enable ? (raw_d ^ polarity) : polarity; // [R8]
   end

   // registers only
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         duty_act_q <= PWT_DUTY_RST;
         raw_q      <= 1'b0;
         pin_q      <= 1'b0;
      end
      else
      begin
         duty_act_q <= duty_act_d;
         raw_q      <= raw_d;
         pin_q      <= pin_d;
      end
   end

endmodule

/* File: tb/pwt_load.sv */
/* pin load: counts high cycles of a pwm pin between two marks.
   assumes mark is one cycle long at the picked timer's reload. */
`timescale 1ns/10ps
module pwt_load
(
   input  wire logic       mclk,  // system clock
   input  wire logic       pin,   // pwm pin
   input  wire logic       mark,  // period boundary
   output logic      [7:0] width  // high cycles of the last period
);
   logic [7:0] cnt_q; // high cycles so far
   // no reset: the first mark clears it
   always_ff @(posedge mclk)
   begin
      cnt_q <= mark ? 8'h00 : cnt_q + {7'h0, pin};
      if (mark)
         width <= cnt_q;
   end
endmodule

/* File: tb/pwt_chk_chk.sv */
/* checker on pwt_top ports: readback, idle level, rise on reload.
   assumes it is bound to pwt_top. */
`timescale 1ns/10ps
module pwt_chk
   import pwt_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata_q,
   input wire logic       t1_reload,
   input wire logic       t2_reload,
   input wire logic       t3_reload,
   input wire logic       pwm_a_q,
   input wire logic       pwm_b_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   logic [3:0] sel_q; // mirrored timer picks
   logic [3:0] ctl_q; // en a, pol a, en b, pol b
   logic [1:0] act_q; // enabled and active high, one cycle late
   logic [2:0] rl;    // reloads, timer one lowest
   logic       rl_a;  // reload of channel a's pick
   logic       rl_b;  // reload of channel b's pick
   assign rl = {t3_reload, t2_reload, t1_reload};
   // the reserved pick gives no reload at all
   assign rl_a = (sel_q[1:0] != 2'h0) && rl[sel_q[1:0] - 2'h1];
   assign rl_b = (sel_q[3:2] != 2'h0) && rl[sel_q[3:2] - 2'h1];
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sel_q <= 4'h5;
         ctl_q <= 4'h0;
         act_q <= 2'h0;
      end
      else
      begin
         if (wr && addr == PWT_OFF_TSEL)
            sel_q <= wdata[3:0];
         if (wr && addr == PWT_OFF_A_CTRL)
            ctl_q[3:2] <= {wdata[7], wdata[4]};
         if (wr && addr == PWT_OFF_B_CTRL)
            ctl_q[1:0] <= {wdata[7], wdata[4]};
         act_q <= {ctl_q[3] & ~ctl_q[2], ctl_q[1] & ~ctl_q[0]};
      end
   end
   ////////////////////////////////////////////////////////////////
   a_tsel_read: assert property (
      $past(rd && addr == PWT_OFF_TSEL) |-> rdata_q == {4'h0, $past(sel_q)})
      else $error("select readback wrong");
   a_tsel_upper: assert property (
      $past(rd && addr == PWT_OFF_TSEL) |-> rdata_q[7:4] == 4'h0)
      else $error("select upper bits not zero");
   a_ctrl_read: assert property (
      $past(rd && addr == PWT_OFF_A_CTRL) |->
      (rdata_q & 8'hDF) == {$past(ctl_q[3]), 2'b00, $past(ctl_q[2]), 4'h0})
      else $error("control readback wrong");
   a_unmapped_zero: assert property (
      $past(rd && addr == 3'h7) |-> rdata_q == 8'h00)
      else $error("unmapped read not zero");
   a_idle_a: assert property (
      !$past(ctl_q[3]) |-> pwm_a_q == $past(ctl_q[2]))
      else $error("channel a idle level wrong");
   a_idle_b: assert property (
      !$past(ctl_q[1]) |-> pwm_b_q == $past(ctl_q[0]))
      else $error("channel b idle level wrong");
   a_rise_a: assert property (
      $rose(pwm_a_q) && $past(act_q[1]) |-> $past(rl_a))
      else $error("channel a rose off its reload");
   a_rise_b: assert property (
      $rose(pwm_b_q) && $past(act_q[0]) |-> $past(rl_b))
      else $error("channel b rose off its reload");
   a_rst_pins: assert property (
      disable iff (1'b0) rst |=> !pwm_a_q && !pwm_b_q)
      else $error("pins not low in reset");
   c_rise_a: cover property ($rose(pwm_a_q) && $past(act_q[1]));
   c_rise_b: cover property ($rose(pwm_b_q) && $past(act_q[0]));
   c_unmapped: cover property ($past(rd && addr == 3'h7));
endmodule

/* File: tb/tb.sv */
/* bench for pwt_top: three free timers, random periods and duties, each pick in turn.
   assumes pwt_load as pin load and pwt_chk bound at the foot. */
`timescale 1ns/10ps
module tb
   import pwt_pkg::*;
;
   logic       mclk, rst, wr, rd;
   logic [2:0] addr;
   logic [7:0] wdata, rdata_q, wid_a, wid_b;
   logic [9:0] base [3]; // timer time bases
   logic [7:0] per [3];  // timer periods
   logic [2:0] rl;       // timer reloads
   logic [1:0] mk;       // reload of each channel's pick
   logic [3:0] sel;      // picks as last written
   logic       pwm_a_q, pwm_b_q;
   int         failures, compares;
   int         cyc = 0;
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////
   // timers clear the cycle after base reaches 4*period+3
   always_ff @(posedge mclk)
      for (int i = 0; i < 3; i++)
         base[i] <= (rst || base[i] == {per[i], 2'h3}) ? 10'h000 : base[i] + 10'h001;
   assign rl = {base[2] == 10'h0, base[1] == 10'h0, base[0] == 10'h0};
   assign mk = {rl[sel[3:2] - 2'h1], rl[sel[1:0] - 2'h1]};
   pwt_top i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_q(rdata_q), .t1_base(base[0]), .t2_base(base[1]), .t3_base(base[2]),
      .t1_reload(rl[0]), .t2_reload(rl[1]), .t3_reload(rl[2]), .pwm_a_q(pwm_a_q),
      .pwm_b_q(pwm_b_q));
   pwt_load i_ld_a (.mclk(mclk), .pin(pwm_a_q), .mark(mk[0]), .width(wid_a));
   pwt_load i_ld_b (.mclk(mclk), .pin(pwm_b_q), .mark(mk[1]), .width(wid_b));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata_q, exp, what);
   endtask
   // wait for the picked reload, then let the load latch its width;
   // mk is looked at mid-cycle so the timers' own update cannot race it
   task automatic wait_mk(input int ch);
      do @(negedge mclk); while (mk[ch] !== 1'b1);
      @(posedge mclk);
      #1;
   endtask
   // duty zero on timer one; a new duty lands only after a full period
   task automatic run(input int ch, input logic [1:0] code);
      logic [9:0] d1;
      logic [9:0] d2;
      logic [2:0] off;
      off = ch ? PWT_OFF_B_CTRL : PWT_OFF_A_CTRL;
      d1 = (code == 2'h1) ? 10'h000 : 10'($urandom % (4 * (per[code - 2'h1] + 1)));
      d2 = 10'($urandom % (4 * (per[code - 2'h1] + 1)));
      sel = ch ? {code, 2'h1} : {2'h1, code};
      wr_reg(PWT_OFF_TSEL, {4'h0, sel});
      wr_reg(off + 3'h1, d1[9:2]);
      wr_reg(off + 3'h2, {d1[1:0], 6'h00});
      wr_reg(off, 8'h80);
      wait_mk(ch);
      wait_mk(ch);
      chk(ch ? wid_b : wid_a, d1[7:0], "width");
      wr_reg(off + 3'h1, d2[9:2]);
      wr_reg(off + 3'h2, {d2[1:0], 6'h00});
      wait_mk(ch);
      chk(ch ? wid_b : wid_a, d1[7:0], "held width");
      wait_mk(ch);
      chk(ch ? wid_b : wid_a, d2[7:0], "new width");
      wr_reg(off, 8'h00);
   endtask
   task automatic close_out;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      sel = 4'h5;
      failures = 0;
      compares = 0;
      void'($urandom(57049));
      for (int i = 0; i < 3; i++)
         per[i] = 8'(3 + $urandom % 8);
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(PWT_OFF_TSEL, 8'h05, "select reset");
      wr_reg(PWT_OFF_TSEL, 8'hFF);
      rd_reg(PWT_OFF_TSEL, 8'h0F, "select upper");
      wr_reg(PWT_OFF_TSEL, 8'h00);
      rd_reg(PWT_OFF_TSEL, 8'h00, "reserved pick");
      wr_reg(3'h7, 8'hFF);
      rd_reg(3'h7, 8'h00, "unmapped");
      wr_reg(PWT_OFF_A_CTRL, 8'h5F);
      rd_reg(PWT_OFF_A_CTRL, 8'h30, "idle level");
      wr_reg(PWT_OFF_A_CTRL, 8'h00);
      wr_reg(PWT_OFF_A_DCH, 8'hA5);
      rd_reg(PWT_OFF_A_DCH, 8'hA5, "duty high");
      wr_reg(PWT_OFF_A_DCL, 8'hFF);
      rd_reg(PWT_OFF_A_DCL, 8'hC0, "duty low");
      $display("registers done");
      for (int ch = 0; ch < 2; ch++)
         for (int c = 1; c < 4; c++)
            run(ch, 2'(c));
      $display("duty done");
      @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(PWT_OFF_TSEL, 8'h05, "select again");
      rd_reg(PWT_OFF_B_CTRL, 8'h00, "control again");
      $display("reset done");
      close_out;
   end
   // a hang counts as a mismatch
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         close_out;
      end
   end
endmodule
bind pwt_top pwt_chk i_chk (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata_q(rdata_q), .t1_reload(t1_reload), .t2_reload(t2_reload),
   .t3_reload(t3_reload), .pwm_a_q(pwm_a_q), .pwm_b_q(pwm_b_q));
